// ===== bench/cpu_model.sv
// cpu side partner: issues register write pulses and drives the reset pin
// assumes the controller samples everything on the rising edge of clock
`timescale 1ns/100ps
module cpu_model
(
  input  wire logic clock,
  output logic       power_control_wr,
  output logic [7:0] power_control_wdata,
  output logic       power_mode_wr,
  output logic [7:0] power_mode_wdata,
  output logic       reset_pin
);
  // idle time values; released data shows the inverse so stale bytes never look valid
  initial
  begin
    power_control_wr = 1'b0;
    power_control_wdata = 8'h00;
    power_mode_wr = 1'b0;
    power_mode_wdata = 8'h00;
    reset_pin = 1'b0;
  end
  // one-cycle write of power_control_reg, launched just after an edge
  task automatic wr_ctrl(input logic [7:0] d);
    @(posedge clock) #1;
    power_control_wr = 1'b1;
    power_control_wdata = d;
    @(posedge clock) #1;
    power_control_wr = 1'b0;
    power_control_wdata = ~d;
  endtask
  // one-cycle write of power_mode_reg; callers pass /4 between the slow rates
  task automatic wr_mode(input logic [7:0] d);
    @(posedge clock) #1;
    power_mode_wr = 1'b1;
    power_mode_wdata = d;
    @(posedge clock) #1;
    power_mode_wr = 1'b0;
    power_mode_wdata = ~d;
  endtask
  // reset pin high for n clocks; never shorter than eight clocks, two machine cycles at clock/4
  task automatic hold_reset(input int n);
    @(posedge clock) #1;
    reset_pin = 1'b1;
    repeat ((n < 8) ? 8 : n) @(posedge clock);
    #1 reset_pin = 1'b0;
  endtask
endmodule

// ===== bench/tb.sv
// self-checking bench for the idle / economy clock controller
// assumes the cpu_model partner and the shared package are compiled first
`timescale 1ns/100ps
module tb;
  import idle_econ_pkg::*;
  logic       clock, rst_b, irq_active, wdt_timeout, wdt_irq_en, wdt_reset_en, wdt_clear;
  logic       pc_wr, pm_wr, reset_pin;
  logic       clk_en, pf_pin;
  logic [7:0] pc_wd, pm_wd;
  logic       cpu_clk_en, core_t, periph_t, idle_mode, wake, ale_h, pss_h, port_hold;
  logic       sys_reset, pc_zero, discard;
  logic [1:0] clk_div_sel;
  int         fail_count = 0;
  int         checks_done = 0;

  cpu_model cpu_u (.clock(clock), .power_control_wr(pc_wr), .power_control_wdata(pc_wd),
    .power_mode_wr(pm_wr), .power_mode_wdata(pm_wd), .reset_pin(reset_pin));
  idle_econ_clock_ctrl dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
    .reset_pin(reset_pin), .power_fail_pin(pf_pin), .power_control_wr(pc_wr),
    .power_control_wdata(pc_wd), .power_mode_wr(pm_wr), .power_mode_wdata(pm_wd),
    .irq_active(irq_active), .wdt_timeout(wdt_timeout), .wdt_irq_en(wdt_irq_en),
    .wdt_reset_en(wdt_reset_en), .wdt_clear(wdt_clear), .cpu_clk_en(cpu_clk_en),
    .core_cycle_tick(core_t), .periph_cycle_tick(periph_t), .idle_mode(idle_mode),
    .wake_to_isr(wake), .ale_hold_high(ale_h), .program_store_strobe_hold(pss_h),
    .port_hold(port_hold), .sys_reset(sys_reset), .pc_load_zero(pc_zero),
    .discard_next(discard), .clk_div_sel(clk_div_sel));

  // 5 ns clock
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one comparison on four-state values
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // output selector so one bounded wait serves seven of the flags
  function automatic logic sigv(input int sel);
    case (sel)
      0: sigv = idle_mode;
      1: sigv = wake;
      2: sigv = discard;
      3: sigv = pc_zero;
      4: sigv = sys_reset;
      5: sigv = core_t;
      default: sigv = periph_t;
    endcase
  endfunction
  // bounded wait, sampled 1 ns after each edge
  task automatic wait_on(input int sel, input int bound);
    for (int i = 0; i <= bound; i++)
    begin
      @(posedge clock) #1;
      if (sigv(sel) === 1'b1) return;
    end
    fail_count++;
    $display("wrong value at %0t: wait on %0d ran out", $time, sel);
    conclude();
  endtask
  // clocks from one tick to the next
  task automatic gap(input int sel, input int exp);
    int n;
    n = 0;
    wait_on(sel, 1100);
    do
    begin
      @(posedge clock) #1;
      n++;
    end
    while (sigv(sel) !== 1'b1 && n < 1100);
    check(n, exp);
    if (n >= 1100) conclude();
  endtask

  task automatic t_reset();
    wait_on(3, 20);
    check(sys_reset, 1'b0);
    check(clk_div_sel, DIV_CODE_4);
    $display("test reset done");
  endtask
  // enter idle, then wake by interrupt (k=0) or watchdog time-out (k=1)
  task automatic t_idle_wake(input int k);
    cpu_u.wr_ctrl(8'h01);
    wait_on(0, 70);
    check({cpu_clk_en, ale_h, pss_h, port_hold}, 4'h7);
    gap(6, 4);
    check({idle_mode, cpu_clk_en}, 2'h2);
    if (k == 0)
      irq_active = 1'b1;
    else
      {wdt_irq_en, wdt_timeout} = 2'h3;
    wait_on(1, 3);
    {irq_active, wdt_timeout} = 2'h0;
    check({idle_mode, cpu_clk_en, port_hold}, 3'h2);
    @(posedge clock) #1;
    check(wake, 1'b0);
    $display("test idle wake %0d done", k);
  endtask
  // reset pin while idle drops the following instruction
  task automatic t_idle_reset();
    cpu_u.wr_ctrl(8'h01);
    wait_on(0, 8);
    fork
      cpu_u.hold_reset(8);
      begin
        wait_on(2, 6);
        check({sys_reset, idle_mode}, 2'h2);
      end
    join
    t_reset();
  endtask
  // each rate, a reserved write after the /64 one; /4 between slow rates
  task automatic t_rates();
    logic [7:0] wd [4] = '{8'h80, 8'h40, 8'hc0, 8'h40};
    int         gp [4] = '{64, 4, 1024, 4};
    int         ol [4] = '{4, 64, 4, 1024};
    int         n;
    for (int i = 0; i < 4; i++)
    begin
      cpu_u.wr_mode(wd[i]);
      n = 0;
      while (clk_div_sel !== wd[i][7:6] && n < 2100)
      begin
        @(posedge clock) #1;
        n++;
      end
      check(n > ol[i] && n <= 2 * ol[i], 1'b1);
      check(clk_div_sel, wd[i][7:6]);
      if (n >= 2100) conclude();
      gap(5, gp[i]);
      gap(6, gp[i]);
      if (i == 0)
      begin
        cpu_u.wr_mode(8'h00);
        repeat (140) @(posedge clock);
        #1 check(clk_div_sel, DIV_CODE_64);
        t_idle_wake(0);
      end
    end
    $display("test rates done");
  endtask
  // cleared time-out gives no reset, uncleared one resets 512 clocks later
  task automatic t_watchdog();
    int n;
    {wdt_irq_en, wdt_reset_en, wdt_timeout} = 3'h3;
    @(posedge clock) #1 wdt_timeout = 1'b0;
    repeat (100) @(posedge clock);
    #1 wdt_clear = 1'b1;
    @(posedge clock) #1 wdt_clear = 1'b0;
    repeat (600) @(posedge clock);
    #1 check(sys_reset, 1'b0);
    cpu_u.wr_mode(8'h80);
    repeat (10) @(posedge clock);
    #1 check(clk_div_sel, DIV_CODE_64);
    wdt_timeout = 1'b1;
    @(posedge clock) #1 wdt_timeout = 1'b0;
    n = 1;
    while (sys_reset !== 1'b1 && n < 600)
    begin
      @(posedge clock) #1;
      n++;
    end
    check(n >= 512 && n <= 515, 1'b1);
    if (n >= 600) conclude();
    wdt_reset_en = 1'b0;
    t_reset();
  endtask
  // power-fail pin seen only once the clock enable returns
  task automatic t_pf_freeze();
    @(posedge clock) #1 {clk_en, pf_pin} = 2'h1;
    repeat (20) @(posedge clock);
    #1 check(sys_reset, 1'b0);
    clk_en = 1'b1;
    wait_on(4, 4);
    pf_pin = 1'b0;
    t_reset();
  endtask

  initial
  begin
    {rst_b, irq_active, wdt_timeout, wdt_irq_en, wdt_reset_en, wdt_clear} = 6'h00;
    {clk_en, pf_pin} = 2'h2;
    repeat (12) @(posedge clock);
    #1 rst_b = 1'b1;
    t_reset();
    t_idle_wake(0);
    t_idle_wake(1);
    t_idle_reset();
    t_rates();
    t_watchdog();
    t_pf_freeze();
    conclude();
  end
endmodule

// ===== common/cycle_tick_if.sv
// carrier between the controller and its machine-cycle divider
// assumes both ends sit on the same oscillator clock
`timescale 1ns/100ps
interface cycle_tick_if;
  logic [1:0] div_code;     // active divide code
  logic       idle;         // cpu clock stopped
  logic       restart;      // force counter back to zero
  logic       core_tick;    // last clock of a core machine cycle
  logic       periph_tick;  // last clock of a peripheral machine cycle

  modport ctrl (output div_code, output idle, output restart,
                input core_tick, input periph_tick);
  modport gen  (input div_code, input idle, input restart,
                output core_tick, output periph_tick);
endinterface

// ===== common/idle_econ_pkg.sv
// constants shared by the idle / economy clock controller and its divider
// assumes one oscillator clock at 200 MHz feeding every block
package idle_econ_pkg;

  localparam int unsigned CLK_PERIOD_PS = 5000;          // oscillator period, 5 ns

  // write data field positions seen on the cpu write strobes
  localparam int unsigned IDLE_BIT_POS   = 0;            // power_control_reg bit 0
  localparam int unsigned DIV_SEL_LO_POS = 6;            // clk_div_sel_lo in power_mode_reg
  localparam int unsigned DIV_SEL_HI_POS = 7;            // clk_div_sel_hi in power_mode_reg

  // clock divide codes {clk_div_sel_hi, clk_div_sel_lo}
  localparam logic [1:0] DIV_CODE_RSVD = 2'h0;           // reserved, ignored
  localparam logic [1:0] DIV_CODE_4    = 2'h1;           // 4 clocks per machine cycle
  localparam logic [1:0] DIV_CODE_64   = 2'h2;           // 64 clocks per machine cycle
  localparam logic [1:0] DIV_CODE_1024 = 2'h3;           // 1024 clocks per machine cycle
  localparam logic [1:0] DIV_CODE_RST  = DIV_CODE_4;     // value after any reset

  // last count of the machine-cycle counter for each rate
  localparam logic [9:0] LAST_CNT_4    = 10'h003;
  localparam logic [9:0] LAST_CNT_64   = 10'h03f;
  localparam logic [9:0] LAST_CNT_1024 = 10'h3ff;

  // timing counts, all in oscillator clocks
  localparam logic [3:0] RST_HOLD_CLKS        = 4'h8;    // two machine cycles at clock/4
  localparam logic [9:0] WDT_RESET_DELAY_CLKS = 10'h200; // 512 clocks after time-out

  // last counter value (clocks per machine cycle minus one) for a divide code
  function automatic logic [9:0] last_count(input logic [1:0] code);
    case (code)
      DIV_CODE_64:   last_count = LAST_CNT_64;
      DIV_CODE_1024: last_count = LAST_CNT_1024;
      default:       last_count = LAST_CNT_4;
    endcase
  endfunction

endpackage

// ===== logic/cycle_divider.sv
// machine-cycle divider: counts oscillator clocks per machine cycle
// assumes restart is raised by the controller on reset and on a rate change
`timescale 1ns/100ps
module cycle_divider
  import idle_econ_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic clk_en,
  cycle_tick_if.gen tick
);

  logic [9:0] cnt_q;        // clocks into the current machine cycle
  logic [9:0] cnt_d;
  logic       core_q;       // core tick register
  logic       periph_q;     // peripheral tick register
  wire  [9:0] last_w = last_count(tick.div_code);
  // >= rather than == so a drop from a slow rate never overshoots
  wire        wrap_w = (cnt_q >= last_w);
  // the low two bits give a clock/4 beat independent of the rate
  wire        quarter_w = (cnt_q[1:0] == 2'h3);

  assign cnt_d = (tick.restart || wrap_w) ? 10'h000 : cnt_q + 10'h001;

  // counter and tick registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_q    <= 10'h000;
      core_q   <= 1'b0;
      periph_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q    <= cnt_d;
      core_q   <= wrap_w && !tick.restart;
      // idle peripherals keep clock/4, otherwise they follow the core rate
      periph_q <= (tick.idle ? quarter_w : wrap_w) && !tick.restart;  // RULE_16 RULE_17
    end
  end

  assign tick.core_tick   = core_q;
  assign tick.periph_tick = periph_q;

  AST_PERIPH_QUARTER: assert property (  // RULE_16
    @(posedge clock) disable iff (!rst_b || !clk_en)
    (tick.idle && periph_q) |=> !periph_q [*3])
    else $error("idle peripheral tick faster than clock/4");

  AST_PERIPH_FOLLOWS_CORE: assert property (  // RULE_17
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $past(!tick.idle) && !$past(tick.restart) |-> (periph_q == core_q))
    else $error("peripheral tick differs from core tick outside idle");

endmodule

// ===== logic/idle_econ_clock_ctrl.sv
// idle and economy clock control: gates the cpu clock in idle, wakes on
// interrupt or reset, holds the reset sequence and selects the machine rate
// assumes cpu write strobes arrive on this clock in the instruction's last cycle
`timescale 1ns/100ps

// How it works
// RULE_01: write one to idle bit enters idle
// RULE_02: idle starts after the setting instruction completes
// RULE_03: cpu clock stops, peripherals keep clocking
// RULE_04: cpu registers frozen while clock gated
// RULE_05: address latch and program strobes held high
// RULE_06: port pins hold their entry levels
// RULE_07: enabled interrupt wakes, clears idle, runs handler
// RULE_08: handler return resumes at idle entry point
// RULE_09: any reset source also ends idle
// RULE_10: reset pin held high eight clocks
// RULE_11: reset loads zero address, restarts without delay
// RULE_12: watchdog runs in idle, time-out wakes
// RULE_13: watchdog reset 512 clocks after time-out
// RULE_14: reset exit skips the instruction after idle
// RULE_15: two-bit code selects 4, 64, 1024 clocks
// RULE_16: idle peripherals run at clock divided four
// RULE_17: economy peripherals share the core's reduced rate
// RULE_18: new divide code applies after one cycle
// RULE_19: software returns to divide four between slow rates
// RULE_20: every reset forces divide by four
// RULE_21: reserved code 00 leaves rate unchanged
module idle_econ_clock_ctrl
(
  input  wire logic       clock,                       // 200 MHz oscillator
  input  wire logic       rst_b,                       // power-on reset, async
  input  wire logic       clk_en,                      // freezes all state when low
  input  wire logic       reset_pin,                   // external reset pin, high active
  input  wire logic       power_fail_pin,              // power-fail detector, high active
  input  wire logic       power_control_wr,            // cpu writes power_control_reg
  input  wire logic [7:0] power_control_wdata,         // data of that write
  input  wire logic       power_mode_wr,               // cpu writes power_mode_reg
  input  wire logic [7:0] power_mode_wdata,            // data of that write
  input  wire logic       irq_active,                  // an enabled interrupt is pending
  input  wire logic       wdt_timeout,                 // watchdog time-out pulse
  input  wire logic       wdt_irq_en,                  // watchdog interrupt enabled
  input  wire logic       wdt_reset_en,                // watchdog reset enabled
  input  wire logic       wdt_clear,                   // software restarts the watchdog
  output logic            cpu_clk_en,                  // cpu clock gate enable
  output logic            core_cycle_tick,             // core machine-cycle tick
  output logic            periph_cycle_tick,           // peripheral machine-cycle tick
  output logic            idle_mode,                   // idle bit of power_control_reg
  output logic            wake_to_isr,                 // pulse: start service routine
  output logic            ale_hold_high,               // force address latch strobe high
  output logic            program_store_strobe_hold,   // force program store strobe high
  output logic            port_hold,                   // freeze port pin levels
  output logic            sys_reset,                   // internal synchronous reset
  output logic            pc_load_zero,                // pulse: load program counter 0000h
  output logic            discard_next,                // pulse: drop prefetched instruction
  output logic [1:0]      clk_div_sel                  // active divide code
);
  import idle_econ_pkg::*;

  cycle_tick_if tick ();                               // link to the divider

  // synchronisers for the two pins
  logic       ext_meta_q;                              // first stage, read only by next
  logic       ext_sync_q;                              // synchronised reset pin
  logic       pf_meta_q;                               // first stage, read only by next
  logic       pf_sync_q;                               // synchronised power fail

  // reset sequencing
  logic       sys_reset_q;                             // internal reset
  logic [3:0] hold_cnt_q;                              // clocks of reset tail left
  logic       pc_zero_q;                               // restart pulse
  logic       discard_q;                               // drop-next pulse

  // watchdog reset delay
  logic       wdt_armed_q;                             // time-out seen, reset pending
  logic [9:0] wdt_cnt_q;                               // clocks since time-out
  logic       wdt_fire_q;                              // watchdog reset request

  // idle control
  logic       idle_pend_q;                             // idle written, waiting cycle end
  logic       idle_q;                                  // idle bit
  logic       wake_q;                                  // wake pulse
  logic       cpu_en_q;                                // cpu clock enable
  logic       ale_q;                                   // strobe and port hold copies
  logic       pss_q;
  logic       port_q;

  // economy control
  logic [1:0] div_q;                                   // active code
  logic [1:0] pend_code_q;                             // written code not yet active
  logic       pend_q;                                  // a code is waiting
  logic       pend_aged_q;                             // one machine cycle has passed

  // decoding
  wire        rst_src_w   = ext_sync_q || pf_sync_q || wdt_fire_q;           // RULE_09
  wire        idle_wr_w   = power_control_wr && power_control_wdata[IDLE_BIT_POS];
  wire [1:0]  wr_code_w   = {power_mode_wdata[DIV_SEL_HI_POS],
                             power_mode_wdata[DIV_SEL_LO_POS]};
  wire        code_ok_w   = power_mode_wr && (wr_code_w != DIV_CODE_RSVD);   // RULE_21
  wire        wake_src_w  = irq_active || (wdt_timeout && wdt_irq_en);       // RULE_07 RULE_12
  wire        wake_w      = idle_q && wake_src_w && !rst_src_w;
  wire        enter_w     = idle_pend_q && tick.core_tick && !wake_src_w && !rst_src_w;
  // holds drop at the wake or reset edge, together with the idle bit
  wire        hold_w      = (idle_q || enter_w) && !wake_w && !rst_src_w;   // RULE_05 RULE_06
  wire        apply_w     = pend_q && pend_aged_q && tick.core_tick;         // RULE_18
  wire        hold_done_w = (hold_cnt_q == 4'h0);
  wire        wdt_last_w  = (wdt_cnt_q == WDT_RESET_DELAY_CLKS - 10'h001);

  // the divider sees the rate, the idle state and a restart request
  assign tick.div_code = div_q;
  assign tick.idle     = idle_q;
  assign tick.restart  = sys_reset_q || apply_w;

  cycle_divider u_divider (
    .clock (clock),
    .rst_b (rst_b),
    .clk_en(clk_en),
    .tick  (tick)
  );

  // two flip-flops before any logic reads a pin
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_meta_q <= 1'b0;
      ext_sync_q <= 1'b0;
      pf_meta_q  <= 1'b0;
      pf_sync_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_meta_q <= reset_pin;
      ext_sync_q <= ext_meta_q;
      pf_meta_q  <= power_fail_pin;
      pf_sync_q  <= pf_meta_q;
    end
  end

  // internal reset: held while a source is active, then a tail counting RST_HOLD_CLKS down to zero;
  // the clock already runs, so execution restarts right after the tail
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sys_reset_q <= 1'b1;
      hold_cnt_q  <= RST_HOLD_CLKS;
      pc_zero_q   <= 1'b0;
      discard_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rst_src_w)
      begin
        // a pin pulse shorter than the hold is not guaranteed by the far side
        sys_reset_q <= 1'b1;                                                  // RULE_10
        hold_cnt_q  <= RST_HOLD_CLKS;
        pc_zero_q   <= 1'b0;
      end
      else if (sys_reset_q && hold_done_w)
      begin
        sys_reset_q <= 1'b0;
        pc_zero_q   <= 1'b1;                                                  // RULE_11
      end
      else
      begin
        hold_cnt_q <= sys_reset_q ? hold_cnt_q - 4'h1 : hold_cnt_q;
        pc_zero_q  <= 1'b0;
      end
      // a reset that ends idle must not let the queued instruction run
      discard_q <= rst_src_w && (idle_q || idle_pend_q);                      // RULE_14
    end
  end

  // watchdog reset delay after the time-out flag
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdt_armed_q <= 1'b0;
      wdt_cnt_q   <= 10'h000;
      wdt_fire_q  <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wdt_timeout && wdt_reset_en)
      begin
        // a time-out in the clearing cycle still arms the reset
        wdt_armed_q <= 1'b1;
        wdt_cnt_q   <= 10'h000;
        wdt_fire_q  <= 1'b0;
      end
      else if (wdt_clear || sys_reset_q)
      begin
        wdt_armed_q <= 1'b0;
        wdt_cnt_q   <= 10'h000;
        wdt_fire_q  <= 1'b0;
      end
      else if (wdt_armed_q)
      begin
        wdt_cnt_q  <= wdt_cnt_q + 10'h001;
        wdt_fire_q <= wdt_last_w;                                             // RULE_13
        wdt_armed_q <= !wdt_last_w;
      end
      else
      begin
        wdt_fire_q <= 1'b0;
      end
    end
  end

  // idle entry, wake and reset exit
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_pend_q <= 1'b0;
      idle_q      <= 1'b0;
      wake_q      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (rst_src_w || sys_reset_q)
      begin
        idle_pend_q <= 1'b0;                                                  // RULE_09
        idle_q      <= 1'b0;
        wake_q      <= 1'b0;
      end
      else if (wake_w)
      begin
        // the cpu keeps its pc, so the handler returns to the entry point
        idle_q <= 1'b0;                                                       // RULE_07 RULE_08
        wake_q <= 1'b1;
      end
      else
      begin
        // the idle write finishes its machine cycle before the gate closes
        idle_pend_q <= idle_wr_w || (idle_pend_q && !tick.core_tick);         // RULE_02
        idle_q      <= idle_q || enter_w;                                     // RULE_01
        wake_q      <= idle_pend_q && tick.core_tick && wake_src_w;
      end
    end
  end

  // output holds change on the same edge as the idle bit, as plain registers
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cpu_en_q <= 1'b0;
      ale_q    <= 1'b0;
      pss_q    <= 1'b0;
      port_q   <= 1'b0;
    end
    else if (clk_en)
    begin
      // gating the clock is what freezes pc, sp, psw and accumulator
      cpu_en_q <= !(idle_q || enter_w) || wake_w;                             // RULE_03 RULE_04
      ale_q    <= hold_w;                                                     // RULE_05
      pss_q    <= hold_w;                                                     // RULE_05
      port_q   <= hold_w;                                                     // RULE_06
    end
  end

  // divide code: held back one machine cycle, reset forces clock/4;
  // switching 64 to 1024 directly is left to software to avoid
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_q       <= DIV_CODE_RST;
      pend_code_q <= DIV_CODE_RST;
      pend_q      <= 1'b0;
      pend_aged_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sys_reset_q || rst_src_w)
      begin
        div_q  <= DIV_CODE_RST;                                               // RULE_20
        pend_q <= 1'b0;
        pend_aged_q <= 1'b0;
      end
      else if (code_ok_w)
      begin
        pend_code_q <= wr_code_w;                                             // RULE_15
        pend_q      <= 1'b1;
        pend_aged_q <= 1'b0;
      end
      else if (apply_w)
      begin
        div_q  <= pend_code_q;                                                // RULE_18
        pend_q <= 1'b0;
        pend_aged_q <= 1'b0;
      end
      else if (pend_q && tick.core_tick)
      begin
        pend_aged_q <= 1'b1;
      end
    end
  end

  assign cpu_clk_en                = cpu_en_q;
  assign core_cycle_tick           = tick.core_tick;
  assign periph_cycle_tick         = tick.periph_tick;
  assign idle_mode                 = idle_q;
  assign wake_to_isr               = wake_q;
  assign ale_hold_high             = ale_q;
  assign program_store_strobe_hold = pss_q;
  assign port_hold                 = port_q;
  assign sys_reset                 = sys_reset_q;
  assign pc_load_zero              = pc_zero_q;
  assign discard_next              = discard_q;
  assign clk_div_sel               = div_q;

  AST_IDLE_ENTRY: assert property (  // RULE_01
    @(posedge clock) disable iff (!rst_b || !clk_en)
    enter_w && !sys_reset_q |=> idle_q && !cpu_en_q && ale_q && port_q)
    else $error("idle not entered at machine cycle end");

  AST_NO_EARLY_IDLE: assert property (  // RULE_02
    @(posedge clock) disable iff (!rst_b || !clk_en)
    idle_wr_w && !idle_q && !tick.core_tick |=> !idle_q)
    else $error("idle began before the setting instruction finished");

  AST_CPU_GATED: assert property (  // RULE_03
    @(posedge clock) disable iff (!rst_b || !clk_en)
    idle_q && $past(idle_q) |-> !cpu_en_q && port_q)
    else $error("cpu clock running during idle");

  AST_STROBES_HIGH: assert property (  // RULE_05
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $past(idle_q) && idle_q |-> ale_q && pss_q)
    else $error("strobes not held high in idle");

  AST_WAKE: assert property (  // RULE_07
    @(posedge clock) disable iff (!rst_b || !clk_en)
    wake_w && !sys_reset_q |=> !idle_q && wake_q && cpu_en_q && !port_q)
    else $error("enabled interrupt did not wake");

  AST_RESET_EXIT: assert property (  // RULE_09
    @(posedge clock) disable iff (!rst_b || !clk_en)
    rst_src_w |=> sys_reset_q && !idle_q)
    else $error("reset did not end idle");

  AST_RESET_TAIL: assert property (  // RULE_11
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $fell(sys_reset_q) |-> pc_zero_q && $past(sys_reset_q, 8))
    else $error("reset tail length wrong or no restart pulse");

  AST_WDT_DELAY: assert property (  // RULE_13
    @(posedge clock) disable iff (!rst_b || !clk_en)
    $rose(wdt_fire_q) |-> wdt_cnt_q == WDT_RESET_DELAY_CLKS)
    else $error("watchdog reset not 512 clocks after time-out");

  AST_RESERVED_CODE: assert property (  // RULE_21
    @(posedge clock) disable iff (!rst_b || !clk_en)
    power_mode_wr && wr_code_w == DIV_CODE_RSVD && !apply_w && !rst_src_w
      && !sys_reset_q |=> $stable(pend_q) && $stable(pend_code_q))
    else $error("reserved divide code changed the rate");

  AST_RATE_RESET: assert property (  // RULE_20
    @(posedge clock) disable iff (!rst_b || !clk_en)
    sys_reset_q |=> div_q == DIV_CODE_4)
    else $error("reset did not restore clock/4");

endmodule
